// ---- logic/du_device_end.sv ----
// Device end: register access, shared interrupt, modem pins and loopback
//
// Operation
// - Both channel requests merge onto one interrupt.
// - Interrupt low only for enabled pending sources.
// - Chip select plus address bit picks channel.
// - User output drives inverse of control bit 3.
// - User outputs high after reset.
// - Low read/write select stores bus byte.
// - High read/write select drives register onto bus.
// - Reset returns all registers and outputs.
// - Reset disables serial output and receive input.
// - Ring input rising edge raises modem status.
// - Request-to-send low while control bit 1 set.
// - Request-to-send high after reset.
// - Request-to-send never gates transmit or receive.
// - Loopback ignores receive pin, feeds transmit back.
// - Remote sender idles receive line high.
// - Terminal ready low while control bit 0 set.
// - Serial output high in reset, idle, loopback.
`timescale 1ns/100ps
module du_device_end
(
	// Clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_b,
	// Host bus and interrupt
	du_bus_if.device                           bus,
	// Channel A modem pins
	input  wire logic                          ringIndicatorInA,
	input  wire logic                          serialInA,
	output logic                               serialOutA,
	output logic                               requestSendOutA,
	output logic                               terminalReadyOutA,
	output logic                               userOutputA,
	// Channel B modem pins
	input  wire logic                          ringIndicatorInB,
	input  wire logic                          serialInB,
	output logic                               serialOutB,
	output logic                               requestSendOutB,
	output logic                               terminalReadyOutB,
	output logic                               userOutputB,
	// Serial engine side, one bit per channel
	input  wire logic [du_pkg::DU_CHANNELS-1:0] engineTx,
	output logic      [du_pkg::DU_CHANNELS-1:0] engineRx
);
	import du_pkg::*;

	// Pin gathering per channel
	logic [DU_CHANNELS-1:0] ringPin;
	logic [DU_CHANNELS-1:0] rxPin;
	assign ringPin = {ringIndicatorInB, ringIndicatorInA};
	assign rxPin   = {serialInB, serialInA};

	// Bus decode shared by both channels
	logic                   take;
	logic                   writeTake;
	logic                   readTake;
	logic [2:0]             regSel;
	logic [DU_CHANNELS-1:0] chanHit;
	assign take      = ~bus.csB;
	assign writeTake = take & ~bus.rw;
	assign readTake  = take & bus.rw;
	assign regSel    = bus.addr[2:0];
	assign chanHit   = bus.addr[DU_CHAN_BIT] ? 2'b10 : 2'b01;

	// Pin synchronisers: two flip-flops before any use
	logic [DU_CHANNELS-1:0] ringMeta;
	logic [DU_CHANNELS-1:0] ringSync;
	logic [DU_CHANNELS-1:0] ringPrev;
	logic [DU_CHANNELS-1:0] rxMeta;
	logic [DU_CHANNELS-1:0] rxSync;
	logic [DU_CHANNELS-1:0] next_ringMeta;
	logic [DU_CHANNELS-1:0] next_ringSync;
	logic [DU_CHANNELS-1:0] next_ringPrev;
	logic [DU_CHANNELS-1:0] next_rxMeta;
	logic [DU_CHANNELS-1:0] next_rxSync;

	// Synchroniser next values
	always_comb
	begin
		next_ringMeta = ringPin;
		next_ringSync = ringMeta;
		next_ringPrev = ringSync;
		next_rxMeta   = rxPin;
		next_rxSync   = rxMeta;
	end

	// Synchroniser registers; idle line level is high
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ringMeta <= {DU_CHANNELS{DU_PIN_RST}};
			ringSync <= {DU_CHANNELS{DU_PIN_RST}};
			ringPrev <= {DU_CHANNELS{DU_PIN_RST}};
			rxMeta   <= {DU_CHANNELS{DU_PIN_RST}};
			rxSync   <= {DU_CHANNELS{DU_PIN_RST}};
		end
		else
		begin
			ringMeta <= next_ringMeta;
			ringSync <= next_ringSync;
			ringPrev <= next_ringPrev;
			rxMeta   <= next_rxMeta;
			rxSync   <= next_rxSync;
		end
	end

	// Per channel views used by the read mux and pins
	wire [7:0]             modemCtlOf [DU_CHANNELS];
	wire [7:0]             ierOf [DU_CHANNELS];
	wire [7:0]             sprOf [DU_CHANNELS];
	wire [DU_CHANNELS-1:0] teriOf;
	wire [DU_CHANNELS-1:0] pendOf;
	wire [DU_CHANNELS-1:0] txPinOf;
	wire [DU_CHANNELS-1:0] rtsPinOf;
	wire [DU_CHANNELS-1:0] dtrPinOf;
	wire [DU_CHANNELS-1:0] op2PinOf;

	genvar ch;
	generate
		for (ch = 0; ch < DU_CHANNELS; ch++)
		begin : gChan
			logic [7:0] modemControlReg;
			logic [7:0] ier;
			logic [7:0] spr;
			logic       teri;
			logic       txPin;
			logic       rtsPin;
			logic       dtrPin;
			logic       op2Pin;
			logic       rxOut;
			logic [7:0] next_modemControlReg;
			logic [7:0] next_ier;
			logic [7:0] next_spr;
			logic       next_teri;
			logic       next_txPin;
			logic       next_rtsPin;
			logic       next_dtrPin;
			logic       next_op2Pin;
			logic       next_rxOut;
			logic       wrHit;
			logic       msrRead;
			logic       ringRise;

			assign wrHit    = writeTake & chanHit[ch];
			assign msrRead  = readTake & chanHit[ch] & (regSel == DU_OFF_MSR);
			assign ringRise = ringSync[ch] & ~ringPrev[ch];

			// Register writes and modem status flag
			always_comb
			begin
				next_modemControlReg = modemControlReg;
				next_ier             = ier;
				next_spr             = spr;
				if (wrHit && regSel == DU_OFF_CTL)
					next_modemControlReg = bus.dataBus;
				if (wrHit && regSel == DU_OFF_IER)
					next_ier = bus.dataBus;
				if (wrHit && regSel == DU_OFF_SPR)
					next_spr = bus.dataBus;
				// A new edge wins over the clear by read
				if (ringRise)
					next_teri = 1'b1;
				else if (msrRead)
					next_teri = 1'b0;
				else
					next_teri = teri;
			end

			// Pin and receive path next values
			always_comb
			begin
				next_rtsPin = ~modemControlReg[DU_CTL_RTS];
				next_dtrPin = ~modemControlReg[DU_CTL_DTR];
				next_op2Pin = ~modemControlReg[DU_CTL_OP2];
				if (modemControlReg[DU_CTL_LOOP])
				begin
					next_txPin = 1'b1;
					next_rxOut = engineTx[ch];
				end
				else
				begin
					next_txPin = engineTx[ch];
					next_rxOut = rxSync[ch];
				end
			end

			// Channel state; pins reset high, paths held idle in reset
			always_ff @(posedge sys_clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					modemControlReg <= DU_CTL_RST;
					ier    <= DU_IER_RST;
					spr    <= DU_SPR_RST;
					teri   <= 1'b0;
					txPin  <= DU_PIN_RST;
					rxOut  <= DU_PIN_RST;
					rtsPin <= DU_PIN_RST;
					dtrPin <= DU_PIN_RST;
					op2Pin <= DU_PIN_RST;
				end
				else
				begin
					modemControlReg <= next_modemControlReg;
					ier    <= next_ier;
					spr    <= next_spr;
					teri   <= next_teri;
					txPin  <= next_txPin;
					rxOut  <= next_rxOut;
					rtsPin <= next_rtsPin;
					dtrPin <= next_dtrPin;
					op2Pin <= next_op2Pin;
				end
			end

			assign modemCtlOf[ch] = modemControlReg;
			assign ierOf[ch]    = ier;
			assign sprOf[ch]    = spr;
			assign teriOf[ch]   = teri;
			assign pendOf[ch]   = ier[DU_IER_MODEM] & teri;
			assign txPinOf[ch]  = txPin;
			assign rtsPinOf[ch] = rtsPin;
			assign dtrPinOf[ch] = dtrPin;
			assign op2PinOf[ch] = op2Pin;
			assign engineRx[ch] = rxOut;
		end
	endgenerate

	// Pin outputs straight from channel flip-flops
	assign serialOutA        = txPinOf[0];
	assign serialOutB        = txPinOf[1];
	assign requestSendOutA   = rtsPinOf[0];
	assign requestSendOutB   = rtsPinOf[1];
	assign terminalReadyOutA = dtrPinOf[0];
	assign terminalReadyOutB = dtrPinOf[1];
	assign userOutputA       = op2PinOf[0];
	assign userOutputB       = op2PinOf[1];

	// Read mux for the selected channel
	logic [7:0] readByte;
	logic       chIdx;
	assign chIdx = bus.addr[DU_CHAN_BIT];
	always_comb
	begin
		readByte = DU_UNMAPPED;
		case (regSel)
			DU_OFF_IER: readByte = ierOf[chIdx];
			DU_OFF_CTL: readByte = modemCtlOf[chIdx];
			DU_OFF_SPR: readByte = sprOf[chIdx];
			DU_OFF_ISR: readByte[DU_ISR_NONE] = ~pendOf[chIdx];
			DU_OFF_MSR:
			begin
				readByte[DU_MSR_TERI] = teriOf[chIdx];
				readByte[DU_MSR_RING] = ~ringSync[chIdx];
			end
			default: readByte = DU_UNMAPPED;
		endcase
	end

	// Bus answer and interrupt drive
	logic [7:0] devData;
	logic       devOe;
	logic       irqOe;
	logic [7:0] next_devData;
	logic       next_devOe;
	logic       next_irqOe;

	always_comb
	begin
		next_devData = readTake ? readByte : devData;
		next_devOe   = readTake;
		next_irqOe   = |pendOf;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			devData <= DU_UNMAPPED;
			devOe   <= 1'b0;
			irqOe   <= 1'b0;
		end
		else
		begin
			devData <= next_devData;
			devOe   <= next_devOe;
			irqOe   <= next_irqOe;
		end
	end

	assign bus.devData = devData;
	assign bus.devOe   = devOe;
	assign bus.irqOe   = irqOe;
	assign bus.irqOut  = 1'b0;
endmodule

// ---- shared/du_pkg.sv ----
// Shared constants and types for the dual channel host bus and modem pin logic
package du_pkg;

	// Sizes
	localparam int DU_CHANNELS = 2;
	localparam int DU_ADDR_W   = 4;
	localparam int DU_DATA_W   = 8;

	// Register offsets within a channel, selected by addr[2:0]
	localparam logic [2:0] DU_OFF_IER = 3'h1;
	localparam logic [2:0] DU_OFF_ISR = 3'h2;
	localparam logic [2:0] DU_OFF_CTL = 3'h4;
	localparam logic [2:0] DU_OFF_MSR = 3'h6;
	localparam logic [2:0] DU_OFF_SPR = 3'h7;

	// Address bit that picks the channel
	localparam int DU_CHAN_BIT = 3;

	// Field positions
	localparam int DU_CTL_DTR   = 0;
	localparam int DU_CTL_RTS   = 1;
	localparam int DU_CTL_OP2   = 3;
	localparam int DU_CTL_LOOP  = 4;
	localparam int DU_IER_MODEM = 3;
	localparam int DU_MSR_TERI  = 2;
	localparam int DU_MSR_RING  = 6;
	localparam int DU_ISR_NONE  = 0;

	// Values after reset
	localparam logic [7:0] DU_CTL_RST  = 8'h00;
	localparam logic [7:0] DU_IER_RST  = 8'h00;
	localparam logic [7:0] DU_SPR_RST  = 8'h00;
	localparam logic [7:0] DU_BUS_IDLE = 8'hff;
	localparam logic [7:0] DU_UNMAPPED = 8'h00;
	localparam logic       DU_PIN_RST  = 1'b1;

	// Host end sequencer
	typedef enum logic [3:0]
	{
		DU_H_IDLE = 4'b0001,
		DU_H_ACC  = 4'b0010,
		DU_H_WAIT = 4'b0100,
		DU_H_DONE = 4'b1000
	} du_host_state_t;

endpackage

// ---- shared/du_bus_if.sv ----
// Parallel host bus and shared interrupt line between host and device ends
`timescale 1ns/100ps
interface du_bus_if;
	import du_pkg::*;

	// Host driven strobes and address
	logic                 csB;
	logic                 rw;
	logic [DU_ADDR_W-1:0] addr;
	logic [DU_DATA_W-1:0] hostData;
	logic                 hostOe;
	// Device driven read data and open-drain interrupt
	logic [DU_DATA_W-1:0] devData;
	logic                 devOe;
	logic                 irqOut;
	logic                 irqOe;
	// Resolved wires
	wire  [DU_DATA_W-1:0] dataBus;
	wire                  irqLine;

	// Bus floats high when nobody drives, interrupt has a pull-up
	assign dataBus = hostOe ? hostData : (devOe ? devData : DU_BUS_IDLE);
	assign irqLine = irqOe ? irqOut : 1'b1;

	modport device
	(
		input  csB, rw, addr, dataBus,
		output devData, devOe, irqOut, irqOe
	);

	modport host
	(
		output csB, rw, addr, hostData, hostOe,
		input  dataBus, irqLine
	);
endinterface

// ---- logic/du_host_end.sv ----
// Host end: turns user requests into single bus accesses and watches the interrupt
`timescale 1ns/100ps
module du_host_end
(
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst_b,
	// Host bus and interrupt
	du_bus_if.host                           bus,
	// User request
	input  wire logic                        reqValid,
	input  wire logic                        reqWrite,
	input  wire logic [du_pkg::DU_ADDR_W-1:0] reqAddr,
	input  wire logic [du_pkg::DU_DATA_W-1:0] reqData,
	output logic                             reqReady,
	// User answer
	output logic                             rspValid,
	output logic      [du_pkg::DU_DATA_W-1:0] rspData,
	output logic                             irqSeen
);
	import du_pkg::*;

	du_host_state_t       state;
	du_host_state_t       next_state;
	logic                 csB;
	logic                 rw;
	logic [DU_ADDR_W-1:0] addr;
	logic [DU_DATA_W-1:0] hostData;
	logic                 hostOe;
	logic                 next_csB;
	logic                 next_rw;
	logic [DU_ADDR_W-1:0] next_addr;
	logic [DU_DATA_W-1:0] next_hostData;
	logic                 next_hostOe;
	logic                 next_reqReady;
	logic                 next_rspValid;
	logic [DU_DATA_W-1:0] next_rspData;
	logic                 next_irqSeen;

	// Access sequencer: one strobe cycle, then collect read data
	always_comb
	begin
		next_state    = state;
		next_csB      = 1'b1;
		next_rw       = rw;
		next_addr     = addr;
		next_hostData = hostData;
		next_hostOe   = 1'b0;
		next_rspValid = 1'b0;
		next_rspData  = rspData;
		next_irqSeen  = ~bus.irqLine;
		case (state)
			DU_H_IDLE:
				if (reqValid)
				begin
					next_state    = DU_H_ACC;
					next_csB      = 1'b0;
					next_rw       = ~reqWrite;
					next_addr     = reqAddr;
					next_hostData = reqData;
					next_hostOe   = reqWrite;
				end
			DU_H_ACC:
				next_state = rw ? DU_H_WAIT : DU_H_IDLE;
			DU_H_WAIT:
			begin
				next_state    = DU_H_DONE;
				next_rspValid = 1'b1;
				next_rspData  = bus.dataBus;
			end
			DU_H_DONE:
				next_state = DU_H_IDLE;
			default:
				next_state = DU_H_IDLE;
		endcase
		next_reqReady = (next_state == DU_H_IDLE);
	end

	// Sequencer registers
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state    <= DU_H_IDLE;
			csB      <= 1'b1;
			rw       <= 1'b1;
			addr     <= '0;
			hostData <= DU_BUS_IDLE;
			hostOe   <= 1'b0;
			reqReady <= 1'b1;
			rspValid <= 1'b0;
			rspData  <= DU_UNMAPPED;
			irqSeen  <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			csB      <= next_csB;
			rw       <= next_rw;
			addr     <= next_addr;
			hostData <= next_hostData;
			hostOe   <= next_hostOe;
			reqReady <= next_reqReady;
			rspValid <= next_rspValid;
			rspData  <= next_rspData;
			irqSeen  <= next_irqSeen;
		end
	end

	assign bus.csB      = csB;
	assign bus.rw       = rw;
	assign bus.addr     = addr;
	assign bus.hostData = hostData;
	assign bus.hostOe   = hostOe;
endmodule

// ---- bench/du_bus_chk.sv ----
// Checker for the host bus and shared interrupt between the two ends
`timescale 1ns/100ps
module du_bus_chk
(
	// Clock and reset
	input wire logic                         sys_clk,
	input wire logic                         rst_b,
	// Bus and interrupt signals
	input wire logic                         csB,
	input wire logic                         rw,
	input wire logic [du_pkg::DU_ADDR_W-1:0] addr,
	input wire logic [du_pkg::DU_DATA_W-1:0] devData,
	input wire logic                         devOe,
	input wire logic                         irqOut,
	input wire logic                         irqOe
);
	import du_pkg::*;

	// One clock domain for every property
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// Access kinds seen on the bus
	sequence rdAcc;
		!csB && rw;
	endsequence
	sequence rdIsr;
		!csB && rw && addr[2:0] == DU_OFF_ISR;
	endsequence

	read_answer_a: assert property (rdAcc |=> devOe)
		else $error("read not answered next cycle");
	write_quiet_a: assert property (!csB && !rw |=> !devOe)
		else $error("write drove the data bus");
	answer_cause_a: assert property (devOe |-> !$past(csB) && $past(rw))
		else $error("bus driven without a read");
	irq_drain_a: assert property (irqOe |-> !irqOut)
		else $error("interrupt pin driven high");
	reset_quiet_a: assert property ($rose(rst_b) |-> !devOe && !irqOe)
		else $error("outputs active after reset");
	irq_drop_a: assert property ($fell(irqOe) |-> !$past(csB, 2))
		else $error("interrupt released without an access");
	unmapped_read_a: assert property (rdAcc ##0 addr[2:0] inside {3'h0, 3'h3, 3'h5} |=> devData == DU_UNMAPPED)
		else $error("unmapped read not zero");
	isr_idle_a: assert property (rdIsr ##1 !irqOe |-> devData[DU_ISR_NONE])
		else $error("status shows pending while line idle");
endmodule

// ---- bench/dual_uart_host_and_modem_pins_test.sv ----
// Self-checking bench for the host and device ends joined by the bus interface
`timescale 1ns/100ps
module dual_uart_host_and_modem_pins_test;
	import du_pkg::*;

	// Clock, reset and stimulus
	logic       sys_clk;
	logic       rst_b;
	logic       reqValid;
	logic       reqWrite;
	logic [3:0] reqAddr;
	logic [7:0] reqData;
	logic       reqReady;
	logic       rspValid;
	logic [7:0] rspData;
	logic       irqSeen;
	logic [1:0] ringIn;
	logic [1:0] serialIn;
	logic [1:0] engineTx;
	logic [1:0] engineRx;
	logic [1:0] serialOut;
	logic [1:0] rtsOut;
	logic [1:0] dtrOut;
	logic [1:0] userOut;
	logic [7:0] ctlVals [5];
	logic [7:0] v;
	int         miscompares;
	int         compares;

	du_bus_if busIf();

	du_host_end u_du_host_end (.sys_clk(sys_clk), .rst_b(rst_b), .bus(busIf), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData), .irqSeen(irqSeen));

	du_device_end u_du_device_end (.sys_clk(sys_clk), .rst_b(rst_b), .bus(busIf),
		.ringIndicatorInA(ringIn[0]), .serialInA(serialIn[0]), .serialOutA(serialOut[0]),
		.requestSendOutA(rtsOut[0]), .terminalReadyOutA(dtrOut[0]), .userOutputA(userOut[0]),
		.ringIndicatorInB(ringIn[1]), .serialInB(serialIn[1]), .serialOutB(serialOut[1]),
		.requestSendOutB(rtsOut[1]), .terminalReadyOutB(dtrOut[1]), .userOutputB(userOut[1]),
		.engineTx(engineTx), .engineRx(engineRx));

	du_bus_chk u_du_bus_chk (.sys_clk(sys_clk), .rst_b(rst_b), .csB(busIf.csB), .rw(busIf.rw),
		.addr(busIf.addr), .devData(busIf.devData), .devOe(busIf.devOe), .irqOut(busIf.irqOut),
		.irqOe(busIf.irqOe));

	// Counted comparison
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// One user request, held until taken; reads wait for the answer
	task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		int i;
		i = 0;
		reqValid = 1'b1;
		reqWrite = wr;
		reqAddr = a;
		reqData = d;
		while (reqReady !== 1'b1 && i < 20)
		begin
			i++;
			@(negedge sys_clk);
		end
		@(negedge sys_clk);
		reqValid = 1'b0;
		while (!wr && rspValid !== 1'b1 && i < 20)
		begin
			i++;
			@(negedge sys_clk);
		end
		q = rspData;
		if (i >= 20)
			check("handshake", 8'h00, 8'hff);
		cycles(1);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		access(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
		logic [7:0] q;
		access(1'b0, a, 8'h00, q);
		check(name, exp, q);
	endtask

	// Ring pin low then back high
	task automatic ring(input int ch);
		ringIn[ch] = 1'b0;
		cycles(4);
		ringIn[ch] = 1'b1;
		cycles(6);
	endtask

	task automatic pins(input int ch, input logic [3:0] exp);
		check("pins", {4'h0, exp}, {4'h0, userOut[ch], rtsOut[ch], dtrOut[ch], serialOut[ch]});
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Hang guard
	initial
	begin
		repeat (4000) @(posedge sys_clk);
		check("watchdog", 8'h00, 8'hff);
		complete_run();
	end

	// Test sequence
	initial
	begin
		{rst_b, reqValid, reqWrite, reqAddr, reqData} = '0;
		{ringIn, serialIn, engineTx} = 6'h3f;
		miscompares = 0;
		compares = 0;
		ctlVals = '{8'h01, 8'h02, 8'h08, 8'h0b, 8'h00};
		cycles(2);
		pins(0, 4'hf);
		pins(1, 4'hf);
		check("engineRx", 8'h03, {6'h0, engineRx});
		rst_b = 1'b1;
		cycles(1);
		rd({1'b0, DU_OFF_CTL}, DU_CTL_RST, "modem control reset");
		$display("test reset done");
		for (int ch = 0; ch < 2; ch++)
			foreach (ctlVals[k])
			begin
				v = ctlVals[k];
				wr({ch[0], DU_OFF_CTL}, v);
				engineTx[ch] = v[3];
				cycles(2);
				pins(ch, {~v[3], ~v[1], ~v[0], v[3]});
				rd({ch[0], DU_OFF_CTL}, v, "modem control");
			end
		$display("test modem pins done");
		wr({1'b1, DU_OFF_CTL}, 8'h10);
		engineTx[1] = 1'b0;
		cycles(5);
		check("loop out", 8'h01, {7'h0, serialOut[1]});
		check("loop rx", 8'h00, {7'h0, engineRx[1]});
		engineTx[1] = 1'b1;
		serialIn[1] = 1'b0;
		cycles(5);
		check("loop rx", 8'h01, {7'h0, engineRx[1]});
		wr({1'b1, DU_OFF_CTL}, 8'h00);
		cycles(5);
		check("pin rx", 8'h00, {7'h0, engineRx[1]});
		serialIn[1] = 1'b1;
		$display("test loopback done");
		wr({1'b0, DU_OFF_SPR}, 8'h5a);
		wr({1'b1, DU_OFF_SPR}, 8'ha5);
		rd({1'b0, DU_OFF_SPR}, 8'h5a, "spr a");
		rd({1'b1, DU_OFF_SPR}, 8'ha5, "spr b");
		wr(4'h3, 8'hff);
		rd(4'h3, DU_UNMAPPED, "unmapped");
		rd({1'b0, DU_OFF_ISR}, 8'h01, "isr idle");
		$display("test registers done");
		wr({1'b0, DU_OFF_IER}, 8'h08);
		ring(0);
		check("irq line", 8'h00, {7'h0, busIf.irqLine});
		check("irq seen", 8'h01, {7'h0, irqSeen});
		rd({1'b1, DU_OFF_ISR}, 8'h01, "isr b");
		rd({1'b0, DU_OFF_ISR}, 8'h00, "isr a");
		rd({1'b0, DU_OFF_MSR}, 8'h04, "msr a");
		cycles(2);
		check("irq line", 8'h01, {7'h0, busIf.irqLine});
		ringIn[0] = 1'b0;
		cycles(3);
		rd({1'b0, DU_OFF_MSR}, 8'h40, "msr ring level");
		wr({1'b0, DU_OFF_IER}, 8'h00);
		ring(0);
		check("irq masked", 8'h01, {7'h0, busIf.irqLine});
		rd({1'b0, DU_OFF_MSR}, 8'h04, "msr a");
		wr({1'b1, DU_OFF_IER}, 8'h08);
		ring(1);
		check("irq b", 8'h00, {7'h0, busIf.irqLine});
		wr({1'b1, DU_OFF_IER}, 8'h00);
		cycles(2);
		check("irq off", 8'h01, {7'h0, busIf.irqLine});
		$display("test interrupt done");
		wr({1'b0, DU_OFF_CTL}, 8'h0b);
		rst_b = 1'b0;
		cycles(2);
		pins(0, 4'hf);
		rst_b = 1'b1;
		cycles(1);
		rd({1'b0, DU_OFF_SPR}, DU_SPR_RST, "spr reset");
		$display("test second reset done");
		complete_run();
	end
endmodule
